// file: include/gdfc_pkg.sv
// Purpose: Shared constants and types for the gate driver fault configuration block
// Assumes: 100 MHz system clock, 32-bit AHB-Lite register access
// Notes:   Register indices are scaled by four to give byte addresses
package gdfc_pkg;

  // ----------------------------------------------------------------
  // Register map (indices; byte address is index times four)
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_CFG1   = 8'hAC;
  localparam logic [7:0]  IDX_CFG2   = 8'hAE;
  localparam logic [7:0]  IDX_STATUS = 8'hB0;
  localparam logic [7:0]  IDX_MASK   = 8'hB1;
  localparam logic [7:0]  IDX_CTRL   = 8'hB2;
  localparam logic [31:0] CFG1_RESET = 32'h1022_8100;
  localparam logic [31:0] CFG2_RESET = 32'h0120_0000;
  localparam int          CFG2_W1C_BIT = 24;
  localparam int          CTRL_CLEAR_BIT = 0;

  // ----------------------------------------------------------------
  // Event bits of status and mask
  // ----------------------------------------------------------------
  localparam int EVT_WIDTH = 3;
  localparam int EVT_OC    = 0;
  localparam int EVT_OV    = 1;
  localparam int EVT_OTW   = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CLK_MHZ        = 100;
  localparam int FILT_0_NS      = 200;
  localparam int FILT_1_NS      = 600;
  localparam int FILT_2_NS      = 1100;
  localparam int FILT_3_NS      = 1600;
  localparam int FILT_0_CYC     = (FILT_0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_1_CYC     = (FILT_1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_2_CYC     = (FILT_2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_3_CYC     = (FILT_3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_SHORT_US = 5000;
  localparam int RETRY_LONG_US  = 500000;
  localparam int RETRY_SHORT_CYC = RETRY_SHORT_US * CLK_MHZ;
  localparam int RETRY_LONG_CYC  = RETRY_LONG_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OC_LATCH,
    OC_RETRY,
    OC_REPORT,
    OC_IGNORE
  } gdfc_oc_mode_t;

  typedef struct packed {
    logic          parity;
    logic [2:0]    rsvd30to28;
    logic [1:0]    slewRateSel;
    logic [5:0]    rsvd25to20;
    logic          overvoltage_level_sel;
    logic          overvoltage_protect_on;
    logic          rsvd17;
    logic          overtemp_warn_report;
    logic [1:0]    rsvd15to14;
    logic [1:0]    overcurrent_filter_time;
    logic          overcurrent_retry_wait;
    logic          overcurrent_threshold_sel;
    gdfc_oc_mode_t overcurrent_response_sel;
    logic [5:0]    rsvd7to2;
    logic [1:0]    sense_amp_gain_sel;
  } gdfc_cfg1_t;

  typedef struct packed {
    logic fault;
    logic detected;
    logic event_;
  } gdfc_oc_stat_t;

endpackage : gdfc_pkg

// file: src/gdfc_oc_guard.sv
// Purpose: Overcurrent deglitch filter and fault response sequencer
// Assumes: Comparator input already selects the chosen trip level
// Notes:   Retry counts are parameters so simulation can shorten them
`timescale 1ns/1ps
module gdfc_oc_guard #(
  parameter int RETRY_SHORT_CYC = gdfc_pkg::RETRY_SHORT_CYC,
  parameter int RETRY_LONG_CYC  = gdfc_pkg::RETRY_LONG_CYC
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  // Comparator input, configuration and latch clear
  input  wire logic                    ocRaw,
  input  wire gdfc_pkg::gdfc_oc_mode_t mode,
  input  wire logic [1:0]              filterSel,
  input  wire logic                    retryLong,
  input  wire logic                    clearLatch,
  // Status
  output gdfc_pkg::gdfc_oc_stat_t      stat
);

  typedef enum logic [1:0] {ST_RUN, ST_LATCHED, ST_WAIT} gdfc_oc_state_t;

  function automatic logic [7:0] filtCycles(input logic [1:0] sel);
    case (sel)
      2'd0:    filtCycles = 8'(gdfc_pkg::FILT_0_CYC);
      2'd1:    filtCycles = 8'(gdfc_pkg::FILT_1_CYC);
      2'd2:    filtCycles = 8'(gdfc_pkg::FILT_2_CYC);
      default: filtCycles = 8'(gdfc_pkg::FILT_3_CYC);
    endcase
  endfunction : filtCycles

  logic [7:0]     filtCnt_q;
  logic           detected;
  logic [31:0]    retryCnt_q;
  gdfc_oc_state_t state_q;

  // ----------------------------------------------------------------
  // Deglitch: condition must hold for the whole selected time
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !ocRaw) begin
      filtCnt_q <= 8'h00;
    end else if (filtCnt_q < filtCycles(filterSel)) begin
      filtCnt_q <= filtCnt_q + 8'h01;
    end
  end
  assign detected = ocRaw && (filtCnt_q >= filtCycles(filterSel));

  // ----------------------------------------------------------------
  // Fault response
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q    <= ST_RUN;
      retryCnt_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (detected && mode == gdfc_pkg::OC_LATCH) begin
            state_q <= ST_LATCHED;
          end else if (detected && mode == gdfc_pkg::OC_RETRY) begin
            state_q    <= ST_WAIT;
            retryCnt_q <= 32'h0000_0000;
          end
        end
        ST_LATCHED: begin
          if (clearLatch) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          // Retry wait runs from the fault, then driving resumes
          if (retryCnt_q + 32'd1 >= 32'(retryLong ? RETRY_LONG_CYC : RETRY_SHORT_CYC)) begin
            state_q <= ST_RUN;
          end else begin
            retryCnt_q <= retryCnt_q + 32'd1;
          end
        end
      endcase
    end
  end

  always_comb begin
    stat.fault    = (state_q != ST_RUN);
    // Report-only mode flags without acting; ignore mode stays silent
    stat.detected = detected && (mode != gdfc_pkg::OC_IGNORE);
    stat.event_   = stat.detected && (state_q == ST_RUN) && (filtCnt_q == filtCycles(filterSel));
  end

endmodule : gdfc_oc_guard

// file: src/gdfc_top.sv
// Purpose: Gate driver and protection configuration register bank on AHB-Lite
// Assumes: Comparator and warning inputs are synchronous to sys_clk
// Notes:   Zero-wait slave; status reads clear the sticky event bits
//
// Operation
// - The first driver configuration register sits at index 0xAC and resets to 0x10228100.
// - Bits 27..26 choose the output slew rate of 25, 50, 150 or 200 V/us.
// - Bit 19 picks the supply overvoltage level, clear for 32 V and set for 20 V.
// - Overvoltage protection acts only while bit 18 is set.
// - The overtemperature warning reaches the fault pin only while bit 16 is set.
// - An overcurrent must last the deglitch time chosen by bits 13..12 (0.2, 0.6, 1.1, 1.6 us).
// - Bit 11 chooses a retry wait of 5 ms or 500 ms.
// - Bit 10 chooses a trip level of 16 A or 24 A.
// - Response code 0 latches the overcurrent fault and code 1 retries automatically.
// - Response code 2 reports without acting and code 3 neither reports nor acts.
// - Bits 1..0 give a sense gain of 0.15, 0.3, 0.6 or 1.2 V/A unless automatic gain is on.
// - The second driver configuration register sits at index 0xAE and resets to 0x01200000.
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module gdfc_top #(
  parameter int RETRY_SHORT_CYC = gdfc_pkg::RETRY_SHORT_CYC,
  parameter int RETRY_LONG_CYC  = gdfc_pkg::RETRY_LONG_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Analog comparators and sensors
  input  wire logic        ocAbove16A,
  input  wire logic        ocAbove24A,
  input  wire logic        motor_supplyAbove20V,
  input  wire logic        motor_supplyAbove32V,
  input  wire logic        overtempWarn,
  input  wire logic        auto_sense_gain_on,
  input  wire logic [1:0]  autoGainSel,
  // Driver controls
  output logic             driverEnable,
  output logic [7:0]       slewRateVpus,
  output logic [1:0]       senseGainCode,
  output logic [10:0]      senseGainMvpa,
  output logic [31:0]      gateDriverCfg2,
  // Fault and interrupt
  output logic             fault_out_n,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] slewDecode(input logic [1:0] sel);
    case (sel)
      2'd0:    slewDecode = 8'd25;
      2'd1:    slewDecode = 8'd50;
      2'd2:    slewDecode = 8'd150;
      default: slewDecode = 8'd200;
    endcase
  endfunction : slewDecode

  function automatic logic [10:0] gainDecode(input logic [1:0] sel);
    case (sel)
      2'd0:    gainDecode = 11'd150;
      2'd1:    gainDecode = 11'd300;
      2'd2:    gainDecode = 11'd600;
      default: gainDecode = 11'd1200;
    endcase
  endfunction : gainDecode

  function automatic logic [7:0] wordIndex(input logic [31:0] addr);
    // Upper or byte address bits set must not alias onto a mapped register
    if (addr[31:10] != 22'h0 || addr[1:0] != 2'h0) begin
      wordIndex = 8'hFF;
    end else begin
      wordIndex = addr[9:2];
    end
  endfunction : wordIndex

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  gdfc_pkg::gdfc_cfg1_t    cfg1_q;
  logic [31:0]             cfg2_q;
  logic [gdfc_pkg::EVT_WIDTH-1:0] status_q;
  logic [gdfc_pkg::EVT_WIDTH-1:0] mask_q;
  logic [gdfc_pkg::EVT_WIDTH-1:0] events;
  logic                    wrPend_q;
  logic [7:0]              wrIdx_q;
  logic                    addrTaken;
  logic                    rdTake;
  logic                    statusRead;
  logic                    clearPulse;
  logic                    ocSelected;
  logic                    ovSelected;
  logic                    ovFault;
  logic                    otwPrev_q;
  logic                    ovPrev_q;
  logic                    irq_q;
  logic                    faultOutN_q;
  logic                    driverEnable_q;
  logic [7:0]              slew_q;
  logic [1:0]              gainCode_q;
  logic [10:0]             gainMvpa_q;
  logic [31:0]             hrdata_q;
  gdfc_pkg::gdfc_oc_stat_t ocStat;

  // ----------------------------------------------------------------
  // AHB-Lite address phase
  // ----------------------------------------------------------------
  assign addrTaken  = hsel && htrans[1] && hready;
  assign rdTake     = addrTaken && !hwrite;
  assign statusRead = rdTake && (wordIndex(haddr) == gdfc_pkg::IDX_STATUS);
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrPend_q <= 1'b0;
      wrIdx_q  <= 8'h00;
    end else begin
      wrPend_q <= addrTaken && hwrite;
      wrIdx_q  <= wordIndex(haddr);
    end
  end

  // Read data is latched at the address phase so it stands from a flop
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rdTake) begin
      if (wordIndex(haddr) == gdfc_pkg::IDX_CFG1) begin
        hrdata_q <= cfg1_q;
      end else if (wordIndex(haddr) == gdfc_pkg::IDX_CFG2) begin
        hrdata_q <= cfg2_q;
      end else if (wordIndex(haddr) == gdfc_pkg::IDX_STATUS) begin
        hrdata_q <= 32'(status_q);
      end else if (wordIndex(haddr) == gdfc_pkg::IDX_MASK) begin
        hrdata_q <= 32'(mask_q);
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Reserved bits are stored as written; software restores their defaults
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg1_q <= gdfc_pkg::CFG1_RESET;
    end else if (wrPend_q && wrIdx_q == gdfc_pkg::IDX_CFG1) begin
      cfg1_q <= hwdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg2_q <= gdfc_pkg::CFG2_RESET;
    end else if (wrPend_q && wrIdx_q == gdfc_pkg::IDX_CFG2) begin
      cfg2_q <= hwdata;
      // Power sequencing disable clears on a written one and ignores a zero
      cfg2_q[gdfc_pkg::CFG2_W1C_BIT] <= cfg2_q[gdfc_pkg::CFG2_W1C_BIT] && !hwdata[gdfc_pkg::CFG2_W1C_BIT];
    end
  end
  assign gateDriverCfg2 = cfg2_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mask_q <= '0;
    end else if (wrPend_q && wrIdx_q == gdfc_pkg::IDX_MASK) begin
      mask_q <= hwdata[gdfc_pkg::EVT_WIDTH-1:0];
    end
  end

  assign clearPulse = wrPend_q && (wrIdx_q == gdfc_pkg::IDX_CTRL) && hwdata[gdfc_pkg::CTRL_CLEAR_BIT];

  // ----------------------------------------------------------------
  // Protection
  // ----------------------------------------------------------------
  assign ocSelected = cfg1_q.overcurrent_threshold_sel ? ocAbove24A : ocAbove16A;
  assign ovSelected = cfg1_q.overvoltage_level_sel ? motor_supplyAbove20V : motor_supplyAbove32V;
  assign ovFault    = ovSelected && cfg1_q.overvoltage_protect_on;

  gdfc_oc_guard #(
    .RETRY_SHORT_CYC (RETRY_SHORT_CYC),
    .RETRY_LONG_CYC  (RETRY_LONG_CYC)
  ) u_oc_guard (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .ocRaw      (ocSelected),
    .mode       (cfg1_q.overcurrent_response_sel),
    .filterSel  (cfg1_q.overcurrent_filter_time),
    .retryLong  (cfg1_q.overcurrent_retry_wait),
    .clearLatch (clearPulse),
    .stat       (ocStat)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ovPrev_q  <= 1'b0;
      otwPrev_q <= 1'b0;
    end else begin
      ovPrev_q  <= ovFault;
      otwPrev_q <= overtempWarn;
    end
  end

  assign events[gdfc_pkg::EVT_OC]  = ocStat.event_;
  assign events[gdfc_pkg::EVT_OV]  = ovFault && !ovPrev_q;
  assign events[gdfc_pkg::EVT_OTW] = overtempWarn && !otwPrev_q;

  // ----------------------------------------------------------------
  // Interrupt status: a new event wins over the clearing read
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status_q <= '0;
    end else begin
      status_q <= (statusRead ? '0 : status_q) | events;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((statusRead ? '0 : status_q) | events) & mask_q);
    end
  end
  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Driver outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      faultOutN_q    <= 1'b1;
      driverEnable_q <= 1'b0;
    end else begin
      faultOutN_q    <= !(ocStat.fault || ocStat.detected || ovFault
                          || (overtempWarn && cfg1_q.overtemp_warn_report));
      driverEnable_q <= !(ocStat.fault || ovFault);
    end
  end
  assign fault_out_n  = faultOutN_q;
  assign driverEnable = driverEnable_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      slew_q     <= 8'd25;
      gainCode_q <= 2'd0;
      gainMvpa_q <= 11'd150;
    end else begin
      slew_q     <= slewDecode(cfg1_q.slewRateSel);
      // Automatic gain overrides the fixed field
      gainCode_q <= auto_sense_gain_on ? autoGainSel : cfg1_q.sense_amp_gain_sel;
      gainMvpa_q <= gainDecode(auto_sense_gain_on ? autoGainSel : cfg1_q.sense_amp_gain_sel);
    end
  end
  assign slewRateVpus  = slew_q;
  assign senseGainCode = gainCode_q;
  assign senseGainMvpa = gainMvpa_q;

endmodule : gdfc_top

// file: dv/gdfc_asserts.sv
// Purpose: Port-level checks for the gdfc_top register bank
// Assumes: Zero-wait slave and a single clock domain
// Notes:   Bound to every gdfc_top instance at the foot of this file
`timescale 1ns/1ps
module gdfc_asserts #(
  parameter int RETRY_SHORT_CYC = 50,
  parameter int RETRY_LONG_CYC  = 200
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Sensors
  input wire logic        ocAbove16A,
  input wire logic        ocAbove24A,
  input wire logic        motor_supplyAbove20V,
  input wire logic        motor_supplyAbove32V,
  input wire logic        auto_sense_gain_on,
  input wire logic [1:0]  autoGainSel,
  // Outputs
  input wire logic        driverEnable,
  input wire logic [7:0]  slewRateVpus,
  input wire logic [1:0]  senseGainCode,
  input wire logic [10:0] senseGainMvpa,
  input wire logic [31:0] gateDriverCfg2,
  input wire logic        fault_out_n,
  input wire logic        irq
);
  logic       rdA;
  logic       wrA;
  logic       wrDp_q;
  logic [2:0] cnt_q;
  logic [7:0] slew_q;
  assign rdA = hsel && htrans[1] && hready && !hwrite;
  assign wrA = hsel && htrans[1] && hready && hwrite && haddr == {22'h0, gdfc_pkg::IDX_CFG1, 2'h0};
  // Counter saturates so a stale write never re-arms the slew check
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrDp_q <= 1'b0;
      cnt_q  <= 3'h7;
      slew_q <= 8'h19;
    end else begin
      wrDp_q <= wrA;
      cnt_q  <= wrDp_q ? 3'h0 : (cnt_q == 3'h7 ? cnt_q : cnt_q + 3'h1);
      if (wrDp_q) begin
        slew_q <= hwdata[27] ? (hwdata[26] ? 8'hC8 : 8'h96) : (hwdata[26] ? 8'h32 : 8'h19);
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_bus_okay; hreadyout && !hresp; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
  property p_rst_out; $fell(sys_rst) |-> fault_out_n && !irq && !driverEnable && slewRateVpus == 8'h19; endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
  property p_cfg2_rst; $fell(sys_rst) |-> gateDriverCfg2 == gdfc_pkg::CFG2_RESET; endproperty
  a_cfg2_rst: assert property (p_cfg2_rst) else $error("second config wrong after reset");
  property p_slew_wr; cnt_q == 3'h3 |-> slewRateVpus == slew_q; endproperty
  a_slew_wr: assert property (p_slew_wr) else $error("slew rate does not follow write");
  property p_gain_pair; senseGainMvpa == (11'h096 << senseGainCode); endproperty
  a_gain_pair: assert property (p_gain_pair) else $error("gain value and code disagree");
  property p_auto_gain; (auto_sense_gain_on && $stable(autoGainSel)) [*3] |-> senseGainCode == autoGainSel; endproperty
  a_auto_gain: assert property (p_auto_gain) else $error("automatic gain not followed");
  property p_oc_filter;
    $fell(driverEnable) && !$past(motor_supplyAbove20V) && !$past(motor_supplyAbove32V)
      |-> $past(ocAbove16A || ocAbove24A, 15);
  endproperty
  a_oc_filter: assert property (p_oc_filter) else $error("driver stopped without lasting overcurrent");
  property p_rd_hold; !rdA |=> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed outside a read");
  property p_unmapped; rdA && haddr[31:10] != 22'h0 |=> hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : gdfc_asserts

bind gdfc_top gdfc_asserts #(.RETRY_SHORT_CYC(RETRY_SHORT_CYC), .RETRY_LONG_CYC(RETRY_LONG_CYC)) u_chk (
  .sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
  .ocAbove16A, .ocAbove24A, .motor_supplyAbove20V, .motor_supplyAbove32V, .auto_sense_gain_on,
  .autoGainSel, .driverEnable, .slewRateVpus, .senseGainCode, .senseGainMvpa, .gateDriverCfg2,
  .fault_out_n, .irq);

// file: dv/gdfc_tb.sv
// Purpose: Self-checking bench for gdfc_top
// Assumes: Short retry counts so both waits fit in the run
// Notes:   Row loop covers field decode, then hand-written cases
`timescale 1ns/1ps
module testbench;
  localparam int RS = 50;
  localparam int RL = 200;
  typedef struct { logic [31:0] cfg; logic [7:0] slew; logic [10:0] mv; int filt; } gdfc_row_t;
  gdfc_row_t   rows [4] = '{'{32'h1022_8000, 8'h19, 11'h096, 20}, '{32'h1422_9401, 8'h32, 11'h12C, 60},
                            '{32'h1822_A002, 8'h96, 11'h258, 110}, '{32'h1C22_B403, 8'hC8, 11'h4B0, 160}};
  logic [4:0]  ovTab [4] = '{5'h07, 5'h0D, 5'h0E, 5'h1C};
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        ocAbove16A = 1'b0;
  logic        ocAbove24A = 1'b0;
  logic        motor_supplyAbove20V = 1'b0;
  logic        motor_supplyAbove32V = 1'b0;
  logic        overtempWarn = 1'b0;
  logic        auto_sense_gain_on = 1'b0;
  logic [1:0]  autoGainSel = 2'h0;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        driverEnable;
  logic [7:0]  slewRateVpus;
  logic [1:0]  senseGainCode;
  logic [10:0] senseGainMvpa;
  logic [31:0] gateDriverCfg2;
  logic        fault_out_n;
  logic        irq;
  logic [31:0] rd;
  int          n_errors = 0;
  int          n_tests = 0;
  always #5 sys_clk = ~sys_clk;
  assign hready = hreadyout;
  gdfc_top #(.RETRY_SHORT_CYC(RS), .RETRY_LONG_CYC(RL)) dut (
    .sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .ocAbove16A, .ocAbove24A, .motor_supplyAbove20V, .motor_supplyAbove32V,
    .overtempWarn, .auto_sense_gain_on, .autoGainSel, .driverEnable, .slewRateVpus,
    .senseGainCode, .senseGainMvpa, .gateDriverCfg2, .fault_out_n, .irq);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  function automatic logic [31:0] adr(input logic [7:0] i);
    return {22'h0, i, 2'h0};
  endfunction : adr
  // Address phase, then data phase; read data is taken at the closing edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int k;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    for (int p = 0; p < 2; p++) begin
      k = 0;
      do begin
        @(posedge sys_clk);
        k++;
      end while (hready !== 1'b1 && k < 20);
      if (k >= 20) begin
        n_errors++;
        results();
      end
      if (p == 0) begin
        htrans <= 2'h0;
        hwdata <= wd;
      end
    end
    rd = hrdata;
  endtask : bus
  task automatic waitDe(input logic v, input int lim, output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (driverEnable !== v && k < lim);
    if (k >= lim) begin
      n_errors++;
      results();
    end
  endtask : waitDe
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    tick(3);
    sys_rst <= 1'b0;
    tick(1);
    chk("slew", 8'h19, slewRateVpus);
    chk("gainMv", 11'h096, senseGainMvpa);
    chk("cfg2Out", gdfc_pkg::CFG2_RESET, gateDriverCfg2);
    bus(0, adr(gdfc_pkg::IDX_CFG1), 0);
    chk("cfg1", gdfc_pkg::CFG1_RESET, rd);
    bus(0, adr(gdfc_pkg::IDX_CFG2), 0);
    chk("cfg2", gdfc_pkg::CFG2_RESET, rd);
    bus(0, 32'h0000_12B0, 0);
    chk("unmapped", 32'h0, rd);
    bus(1, adr(gdfc_pkg::IDX_MASK), 32'h1);
    for (int i = 0; i < 4; i++) begin
      bus(1, adr(gdfc_pkg::IDX_CFG1), rows[i].cfg);
      tick(3);
      chk("slew", rows[i].slew, slewRateVpus);
      chk("gainMv", rows[i].mv, senseGainMvpa);
      bus(0, adr(gdfc_pkg::IDX_CFG1), 0);
      chk("cfg1Back", rows[i].cfg, rd);
      if (rows[i].cfg[10]) begin
        ocAbove16A <= 1'b1;
        tick(rows[i].filt + 10);
        chk("below24A", 1, driverEnable);
      end
      ocAbove16A <= 1'b1;
      ocAbove24A <= 1'b1;
      waitDe(0, 300, k);
      chk("filterTime", 1, k >= rows[i].filt && k <= rows[i].filt + 4);
      tick(2);
      chk("irqOc", 1, irq);
      bus(0, adr(gdfc_pkg::IDX_STATUS), 0);
      chk("ocEvent", 32'h1, rd);
      bus(0, adr(gdfc_pkg::IDX_STATUS), 0);
      chk("evtCleared", 32'h0, rd);
      ocAbove16A <= 1'b0;
      ocAbove24A <= 1'b0;
      tick(5);
      chk("latched", 0, driverEnable);
      chk("irqClear", 0, irq);
      bus(1, adr(gdfc_pkg::IDX_CTRL), 32'h1);
      tick(3);
      chk("released", 1, driverEnable);
    end
    for (int j = 0; j < 2; j++) begin
      bus(1, adr(gdfc_pkg::IDX_CFG1), 32'h1022_8100 | (32'(j) << 11));
      ocAbove16A <= 1'b1;
      waitDe(0, 100, k);
      ocAbove16A <= 1'b0;
      waitDe(1, 400, k);
      chk("retryWait", 1, k >= (j ? RL : RS) - 5 && k <= (j ? RL : RS) + 5);
      bus(0, adr(gdfc_pkg::IDX_STATUS), 0);
    end
    for (int m = 2; m < 4; m++) begin
      bus(1, adr(gdfc_pkg::IDX_CFG1), 32'h1022_8000 | (32'(m) << 8));
      ocAbove16A <= 1'b1;
      tick(40);
      chk("reportPin", m == 3, fault_out_n);
      chk("reportDrive", 1, driverEnable);
      ocAbove16A <= 1'b0;
      tick(3);
      bus(0, adr(gdfc_pkg::IDX_STATUS), 0);
      chk("reportEvt", m == 2, rd);
    end
    // Overvoltage events stay masked, so the line must not rise
    for (int i = 0; i < 4; i++) begin
      bus(1, adr(gdfc_pkg::IDX_CFG1), 32'h1022_8100 | {12'h0, ovTab[i][4:3], 18'h0});
      motor_supplyAbove20V <= ovTab[i][2];
      motor_supplyAbove32V <= ovTab[i][1];
      tick(4);
      chk("ovPin", ovTab[i][0], fault_out_n);
      motor_supplyAbove20V <= 1'b0;
      motor_supplyAbove32V <= 1'b0;
      tick(3);
    end
    chk("irqMasked", 0, irq);
    bus(0, adr(gdfc_pkg::IDX_STATUS), 0);
    chk("ovEvt", 32'h2, rd);
    bus(1, adr(gdfc_pkg::IDX_MASK), 32'h4);
    for (int b = 0; b < 2; b++) begin
      bus(1, adr(gdfc_pkg::IDX_CFG1), 32'h1022_8100 | (32'(b) << 16));
      overtempWarn <= 1'b1;
      tick(4);
      chk("otwPin", b == 0, fault_out_n);
      overtempWarn <= 1'b0;
      tick(3);
    end
    chk("irqOtw", 1, irq);
    bus(0, adr(gdfc_pkg::IDX_STATUS), 0);
    chk("otwEvt", 32'h4, rd);
    tick(3);
    chk("irqOtwClr", 0, irq);
    bus(1, adr(gdfc_pkg::IDX_CFG2), 32'h0160_0000);
    bus(0, adr(gdfc_pkg::IDX_CFG2), 0);
    chk("cfg2W1c", 32'h0060_0000, rd);
    auto_sense_gain_on <= 1'b1;
    autoGainSel <= 2'h3;
    tick(4);
    chk("autoGain", 2'h3, senseGainCode);
    auto_sense_gain_on <= 1'b0;
    tick(4);
    chk("manualGain", 2'h0, senseGainCode);
    sys_rst <= 1'b1;
    tick(3);
    sys_rst <= 1'b0;
    tick(1);
    bus(0, adr(gdfc_pkg::IDX_CFG1), 0);
    chk("cfg1Again", gdfc_pkg::CFG1_RESET, rd);
    chk("cfg2Again", gdfc_pkg::CFG2_RESET, gateDriverCfg2);
    results();
  end
endmodule : testbench
